// [pmplf_chk.sv]
// Assertion checker watching the ports of the protection lock and fault block.
`timescale 1ns/1ps
module pmplf_chk
  import pmplf_pkg::*;
#(
  parameter int ID_W = 6
) (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic [31:0] bus_addr_i,
  input  wire logic [31:0] bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_supervisor_i,
  input  wire logic [31:0] bus_rdata_o,
  input  wire logic        fault_valid_i,
  input  wire logic        fault_exception_o,
  input  wire logic        engaged_flag_o,
  input  wire logic        page_attr_wr_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // A read strobe at one address; its data stand in the following cycle.
  sequence rd_at(logic [31:0] a);
    bus_rd_i && bus_addr_i == a;
  endsequence
  state_read_a: assert property (
    rd_at(PMPLF_LOCK_STATE_OFS) |=> bus_rdata_o[31:1] == 31'h0) else $error("state high bits");
  state_bit_a: assert property (
    rd_at(PMPLF_LOCK_STATE_OFS) |=> bus_rdata_o[0] == $past(engaged_flag_o))
    else $error("state bit differs from lock");
  stat_rsvd_a: assert property (
    rd_at(PMPLF_FAULT_STATUS_OFS) |=> bus_rdata_o[31:16] == 16'h0 && bus_rdata_o[7:6] == 2'h0
      && !bus_rdata_o[3] && !bus_rdata_o[0]) else $error("status reserved bits set");
  local_id_a: assert property (
    rd_at(PMPLF_FAULT_STATUS_OFS) ##1 bus_rdata_o[8] |-> bus_rdata_o[15:9] == 7'h0)
    else $error("local fault kept an id");
  narrow_id_a: assert property (
    rd_at(PMPLF_FAULT_STATUS_OFS) |=> (bus_rdata_o[15:9] >> ID_W) == 7'h0)
    else $error("id upper bits set");
  // Lock changes need a supervisor command write in the cycle before; reset leaves it at 0.
  lock_cause_a: assert property (
    $rose(engaged_flag_o) |-> $past(bus_wr_i) && $past(bus_supervisor_i)
      && $past(bus_wdata_i[1]) && $past(bus_addr_i) == PMPLF_LOCK_COMMAND_OFS)
    else $error("lock engaged without command");
  unlock_cause_a: assert property (
    $fell(engaged_flag_o) |-> $past(bus_wr_i) && $past(bus_supervisor_i)
      && $past(bus_wdata_i[0]) && $past(bus_addr_i) == PMPLF_LOCK_COMMAND_OFS)
    else $error("lock dropped without command");
  // Read data stand only in the cycle after a read strobe and are zero otherwise.
  rdata_idle_a: assert property (
    !bus_rd_i |=> bus_rdata_o == 32'h0) else $error("read data outside a read");
  exc_cause_a: assert property (
    fault_exception_o |-> $past(fault_valid_i)) else $error("exception without fault");
  page_gate_a: assert property (
    page_attr_wr_o == (bus_wr_i && bus_supervisor_i && !engaged_flag_o
      && bus_addr_i >= PMPLF_PAGE_ATTR_BASE && bus_addr_i <= PMPLF_PAGE_ATTR_LAST))
    else $error("page write gate wrong");
endmodule

// [pmplf_pkg.sv]
// Constants, register map and types for the program memory protection lock and fault block.
// Function
// RULE_01: Lock command decodes status reset, lock, unlock.
// RULE_02: Lock engages only after correct key sequence.
// RULE_03: Unlock disengages only after correct key sequence.
// RULE_04: Lock state bit zero shows engagement.
// RULE_05: Only the first 64 key bits count.
// RULE_06: Third and fourth key writes are ignored.
// RULE_07: Violations are captured in address and status.
// RULE_08: Fault registers sit at consecutive word addresses.
// RULE_09: Fault address holds full 32-bit faulting address.
// RULE_10: Status bits 15 to 9 hold requestor ID.
// RULE_11: Narrow requestor IDs read zero above.
// RULE_12: Wide requestor IDs truncate to seven bits.
// RULE_13: Local fault sets bit 8, zeroes ID.
// RULE_14: Bit 8 marks a local processor fault.
// RULE_15: Bits 5 and 4 flag supervisor read, write.
// RULE_16: Bits 2 and 1 flag user read, write.
// RULE_17: Keep first fault; local may replace remote.
// RULE_18: Writing one to fault clear drops the record.
// RULE_19: A 64-bit key guards protection configuration writes.
// RULE_20: Engaged lock blocks page permission attribute writes.
package pmplf_pkg;

  // Register byte addresses.
  localparam logic [31:0] PMPLF_FAULT_ADDRESS_OFS = 32'h0184a400;
  localparam logic [31:0] PMPLF_FAULT_STATUS_OFS  = 32'h0184a404;
  localparam logic [31:0] PMPLF_FAULT_CLEAR_OFS   = 32'h0184a408;
  localparam logic [31:0] PMPLF_KEY_FIRST_OFS     = 32'h0184a500;
  localparam logic [31:0] PMPLF_KEY_SECOND_OFS    = 32'h0184a504;
  localparam logic [31:0] PMPLF_KEY_THIRD_OFS     = 32'h0184a508;
  localparam logic [31:0] PMPLF_KEY_FOURTH_OFS    = 32'h0184a50c;
  localparam logic [31:0] PMPLF_LOCK_COMMAND_OFS  = 32'h0184a510;
  localparam logic [31:0] PMPLF_LOCK_STATE_OFS    = 32'h0184a514;

  // Page permission attribute window, decoded only to gate writes.
  localparam logic [31:0] PMPLF_PAGE_ATTR_BASE    = 32'h0184a200;
  localparam logic [31:0] PMPLF_PAGE_ATTR_LAST    = 32'h0184a2fc;

  // Lock command bit positions.
  localparam int PMPLF_CMD_STATUS_RESET_BIT = 2;
  localparam int PMPLF_CMD_LOCK_BIT         = 1;
  localparam int PMPLF_CMD_UNLOCK_BIT       = 0;

  // Lock state and fault clear bit positions.
  localparam int PMPLF_ENGAGED_BIT          = 0;
  localparam int PMPLF_CLEAR_FAULT_BIT      = 0;

  // Fault status field positions.
  localparam int PMPLF_FID_LSB              = 9;
  localparam int PMPLF_FID_W                = 7;
  localparam int PMPLF_LOCAL_BIT            = 8;
  localparam int PMPLF_SUP_READ_BIT         = 5;
  localparam int PMPLF_SUP_WRITE_BIT        = 4;
  localparam int PMPLF_USER_READ_BIT        = 2;
  localparam int PMPLF_USER_WRITE_BIT       = 1;

  // Reset values.
  localparam logic [31:0] PMPLF_WORD_RST    = 32'h00000000;
  localparam logic [63:0] PMPLF_KEY_RST     = 64'h0000000000000000;

  // Progress of the key entry sequence.
  typedef enum logic [1:0] {
    PMPLF_SEQ_IDLE   = 2'b00,
    PMPLF_SEQ_FIRST  = 2'b01,
    PMPLF_SEQ_READY  = 2'b10
  } pmplf_seq_type;

endpackage

// [pmplf_req_model.sv]
// Behavioural model of the core and DMA requestors that report denied accesses.
`timescale 1ns/1ps
module pmplf_req_model #(
  parameter int ID_W = 6
) (
  input  wire logic            clock_i,
  output logic                 fault_valid_o,
  output logic [31:0]          fault_addr_o,
  output logic [ID_W-1:0]      fault_id_o,
  output logic                 fault_local_o,
  output logic [3:0]           fault_kind_o
);
  // Quiet lines at time zero.
  initial begin
    fault_valid_o = 1'b0;
    fault_addr_o = 32'h0;
    fault_id_o = '0;
    fault_local_o = 1'b0;
    fault_kind_o = 4'h0;
  end
  // One-cycle report; kind is {sup read, sup write, user read, user write}.
  task automatic issue(input logic [31:0] a, input logic [ID_W-1:0] id, input logic loc,
                       input logic [3:0] k);
    @(posedge clock_i);
    fault_valid_o <= 1'b1;
    fault_addr_o <= a;
    fault_id_o <= id;
    fault_local_o <= loc;
    fault_kind_o <= k;
    @(posedge clock_i);
    // Details are inverted afterwards so a stale sample cannot pass for a fresh one.
    fault_valid_o <= 1'b0;
    fault_addr_o <= ~a;
    fault_id_o <= ~id;
    fault_local_o <= ~loc;
    fault_kind_o <= ~k;
  endtask
endmodule

// [pmplf_tb_top.sv]
// Self-checking bench for the protection lock and fault block.
`timescale 1ns/1ps
module pmplf_tb_top;
  import pmplf_pkg::*;
  localparam logic [63:0] K = 64'h0f0f5a5a1234abcd;
  logic        clock_i, arst_n_i, bus_wr_i, bus_rd_i, bus_supervisor_i, fault_valid_i;
  logic        fault_local_i, fault_exception_o, engaged_flag_o, page_attr_wr_o, pw;
  logic [31:0] bus_addr_i, bus_wdata_i, bus_rdata_o, fault_addr_i;
  logic [5:0]  fault_id_i;
  logic [3:0]  fk;
  int          num_errors, n_checks, cyc;
  pmplf_top #(.ID_W(6)) i_dut (.fault_sup_read_i(fk[3]), .fault_sup_write_i(fk[2]),
    .fault_user_read_i(fk[1]), .fault_user_write_i(fk[0]), .*);
  pmplf_req_model #(.ID_W(6)) i_req (.clock_i(clock_i), .fault_valid_o(fault_valid_i),
    .fault_addr_o(fault_addr_i), .fault_id_o(fault_id_i), .fault_local_o(fault_local_i),
    .fault_kind_o(fk));
  // Free-running 200 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles; the page gate is sampled while the write strobe stands.
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus_wr_i <= 1'b1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    #1 pw = page_attr_wr_o;
    @(posedge clock_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    bus_rd_i <= 1'b1;
    bus_addr_i <= a;
    @(posedge clock_i);
    bus_rd_i <= 1'b0;
    #1 chk(bus_rdata_o, exp);
  endtask
  task automatic key(input logic [63:0] k);
    wr_reg(PMPLF_KEY_FIRST_OFS, k[31:0]);
    wr_reg(PMPLF_KEY_SECOND_OFS, k[63:32]);
  endtask
  task automatic t_lock;
    wr_reg(PMPLF_LOCK_COMMAND_OFS, 32'h2);
    rd_chk(PMPLF_LOCK_STATE_OFS, 32'h0);
    key(K);
    wr_reg(PMPLF_LOCK_COMMAND_OFS, 32'h4);
    wr_reg(PMPLF_LOCK_COMMAND_OFS, 32'h2);
    rd_chk(PMPLF_LOCK_STATE_OFS, 32'h0);
    key(K);
    wr_reg(PMPLF_LOCK_COMMAND_OFS, 32'h2);
    rd_chk(PMPLF_LOCK_STATE_OFS, 32'h1);
    wr_reg(PMPLF_PAGE_ATTR_BASE, 32'h1ff);
    chk({31'h0, pw}, 32'h0);
    key(K ^ 64'h1);
    wr_reg(PMPLF_LOCK_COMMAND_OFS, 32'h1);
    rd_chk(PMPLF_LOCK_STATE_OFS, 32'h1);
    key(K);
    wr_reg(PMPLF_KEY_THIRD_OFS, 32'h5555aaaa);
    wr_reg(PMPLF_KEY_FOURTH_OFS, 32'h3c3c3c3c);
    wr_reg(PMPLF_LOCK_COMMAND_OFS, 32'h1);
    rd_chk(PMPLF_LOCK_STATE_OFS, 32'h0);
    wr_reg(PMPLF_PAGE_ATTR_BASE, 32'h1ff);
    chk({31'h0, pw}, 32'h1);
    $display("test lock done");
  endtask
  task automatic t_fault;
    i_req.issue(32'hdead0010, 6'h2b, 1'b0, 4'b1000);
    #1 chk({31'h0, fault_exception_o}, 32'h1);
    rd_chk(PMPLF_FAULT_ADDRESS_OFS, 32'hdead0010);
    rd_chk(PMPLF_FAULT_STATUS_OFS, 32'h00005620);
    i_req.issue(32'h11110000, 6'h01, 1'b0, 4'b0010);
    #1 chk({31'h0, fault_exception_o}, 32'h0);
    rd_chk(PMPLF_FAULT_ADDRESS_OFS, 32'hdead0010);
    i_req.issue(32'hbeef0004, 6'h15, 1'b1, 4'b0001);
    #1 chk({31'h0, fault_exception_o}, 32'h1);
    rd_chk(PMPLF_FAULT_STATUS_OFS, 32'h00000102);
    wr_reg(PMPLF_FAULT_CLEAR_OFS, 32'h0);
    rd_chk(PMPLF_FAULT_ADDRESS_OFS, 32'hbeef0004);
    wr_reg(PMPLF_FAULT_CLEAR_OFS, 32'h1);
    rd_chk(PMPLF_FAULT_STATUS_OFS, 32'h0);
    i_req.issue(32'h00000400, 6'h3f, 1'b0, 4'b0110);
    rd_chk(PMPLF_FAULT_STATUS_OFS, 32'h00007e14);
    $display("test fault done");
  endtask
  // After reset the lock is disengaged, both on the pin and in the state register.
  task automatic t_reset;
    rd_chk(PMPLF_LOCK_STATE_OFS, 32'h0);
    chk({31'h0, engaged_flag_o}, 32'h0);
    $display("test reset done");
  endtask
  // User-mode writes must change nothing; a ready key sequence survives them.
  task automatic t_user;
    key(K);
    @(posedge clock_i);
    bus_supervisor_i <= 1'b0;
    wr_reg(PMPLF_PAGE_ATTR_BASE, 32'h1ff);
    chk({31'h0, pw}, 32'h0);
    wr_reg(PMPLF_FAULT_CLEAR_OFS, 32'h1);
    wr_reg(PMPLF_LOCK_COMMAND_OFS, 32'h2);
    bus_supervisor_i <= 1'b1;
    rd_chk(PMPLF_LOCK_STATE_OFS, 32'h0);
    rd_chk(PMPLF_FAULT_ADDRESS_OFS, 32'h00000400);
    wr_reg(PMPLF_LOCK_COMMAND_OFS, 32'h2);
    rd_chk(PMPLF_LOCK_STATE_OFS, 32'h1);
    chk({31'h0, engaged_flag_o}, 32'h1);
    $display("test user done");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // A hang is cut short well past the expected run of about a hundred cycles.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    {arst_n_i, bus_wr_i, bus_rd_i, bus_addr_i, bus_wdata_i} = '0;
    bus_supervisor_i = 1'b1;
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_lock();
    t_fault();
    t_user();
    end_sim();
  end
endmodule
bind pmplf_top pmplf_chk #(.ID_W(ID_W)) i_chk (.*);

// [pmplf_top.sv]
// Lock control and fault recording for the level-one program memory protection unit.
`timescale 1ns/1ps
module pmplf_top
  import pmplf_pkg::*;
#(
  parameter int ID_W = 6
) (
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  input  wire logic [31:0]       bus_addr_i,
  input  wire logic [31:0]       bus_wdata_i,
  input  wire logic              bus_wr_i,
  input  wire logic              bus_rd_i,
  input  wire logic              bus_supervisor_i,
  output logic      [31:0]       bus_rdata_o,
  input  wire logic              fault_valid_i,
  input  wire logic [31:0]       fault_addr_i,
  input  wire logic [ID_W-1:0]   fault_id_i,
  input  wire logic              fault_local_i,
  input  wire logic              fault_sup_read_i,
  input  wire logic              fault_sup_write_i,
  input  wire logic              fault_user_read_i,
  input  wire logic              fault_user_write_i,
  output logic                   fault_exception_o,
  output logic                   engaged_flag_o,
  output logic                   page_attr_wr_o
);

  // Refuse widths the capture logic cannot serve.
  if (ID_W < 1) begin : g_bad_id_w
    $error("ID_W must be at least one");
  end

  // All state of the block.
  typedef struct packed {
    logic          engaged;
    logic [63:0]   stored_key;
    logic [63:0]   entry_key;
    pmplf_seq_type seq;
    logic          fault_held;
    logic [31:0]   fault_address;
    logic [31:0]   fault_status;
    logic          exception;
    logic [31:0]   rdata;
  } pmplf_state_type;

  pmplf_state_type st_q;
  pmplf_state_type st_d;

  // Fits a requestor ID into the seven-bit field, zero-extending or truncating.
  function automatic logic [PMPLF_FID_W-1:0] fit_id(input logic [ID_W-1:0] id);
    logic [PMPLF_FID_W+ID_W-1:0] wide;
    wide = '0;
    wide[ID_W-1:0] = id;
    return wide[PMPLF_FID_W-1:0]; // [RULE_11] [RULE_12]
  endfunction

  // Compares the bus address against one register offset.
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
    return addr == ofs;
  endfunction

  logic wr_ok;
  logic cmd_write;
  logic key_first_write;
  logic key_second_write;
  logic key_ignored_write;
  logic clear_write;
  logic page_attr_hit;
  logic take_fault;
  logic [31:0] new_status;

  // Configuration writes are honoured only from supervisor mode.
  assign wr_ok             = bus_wr_i & bus_supervisor_i;
  assign cmd_write         = wr_ok & hit(bus_addr_i, PMPLF_LOCK_COMMAND_OFS);
  assign key_first_write   = wr_ok & hit(bus_addr_i, PMPLF_KEY_FIRST_OFS);
  assign key_second_write  = wr_ok & hit(bus_addr_i, PMPLF_KEY_SECOND_OFS);
  assign key_ignored_write = wr_ok & (hit(bus_addr_i, PMPLF_KEY_THIRD_OFS) |
                                      hit(bus_addr_i, PMPLF_KEY_FOURTH_OFS));
  assign clear_write       = wr_ok & hit(bus_addr_i, PMPLF_FAULT_CLEAR_OFS) &
                             bus_wdata_i[PMPLF_CLEAR_FAULT_BIT]; // [RULE_18]
  assign page_attr_hit     = (bus_addr_i >= PMPLF_PAGE_ATTR_BASE) &
                             (bus_addr_i <= PMPLF_PAGE_ATTR_LAST);

  // The whole protection unit sees attribute writes only while disengaged.
  assign page_attr_wr_o    = wr_ok & page_attr_hit & ~st_q.engaged; // [RULE_20] [RULE_19]

  // First fault wins; a local fault may displace a remote one.
  assign take_fault = fault_valid_i &
                      (~st_q.fault_held |
                       (fault_local_i & ~st_q.fault_status[PMPLF_LOCAL_BIT])); // [RULE_17]

  // Assemble the status word of the incoming fault.
  always_comb begin
    new_status = PMPLF_WORD_RST;
    new_status[PMPLF_FID_LSB +: PMPLF_FID_W] =
      fault_local_i ? '0 : fit_id(fault_id_i); // [RULE_10] [RULE_13]
    new_status[PMPLF_LOCAL_BIT]      = fault_local_i; // [RULE_14] [RULE_13]
    new_status[PMPLF_SUP_READ_BIT]   = fault_sup_read_i; // [RULE_15]
    new_status[PMPLF_SUP_WRITE_BIT]  = fault_sup_write_i; // [RULE_15]
    new_status[PMPLF_USER_READ_BIT]  = fault_user_read_i; // [RULE_16]
    new_status[PMPLF_USER_WRITE_BIT] = fault_user_write_i; // [RULE_16]
  end

  // Next-state logic for the lock, key sequence, fault record and read port.
  always_comb begin
    st_d           = st_q;
    st_d.exception = 1'b0;
    st_d.rdata     = PMPLF_WORD_RST;

    // Key sequence: first word, then second word, then a command.
    // Writes to the third and fourth key words neither store nor disturb it.
    if (key_first_write) begin
      st_d.entry_key[31:0] = bus_wdata_i; // [RULE_05] [RULE_19]
      st_d.seq             = PMPLF_SEQ_FIRST;
    end else if (key_second_write) begin
      st_d.entry_key[63:32] = bus_wdata_i; // [RULE_05]
      st_d.seq = (st_q.seq == PMPLF_SEQ_FIRST) ? PMPLF_SEQ_READY : PMPLF_SEQ_IDLE;
    end else if (key_ignored_write) begin
      st_d.seq = st_q.seq; // [RULE_06]
    end

    // Command decode; zero bits do nothing, status reset outranks the rest.
    if (cmd_write) begin
      if (bus_wdata_i[PMPLF_CMD_STATUS_RESET_BIT]) begin // [RULE_01]
        st_d.seq = PMPLF_SEQ_IDLE;
      end else if (bus_wdata_i[PMPLF_CMD_LOCK_BIT] &
                   ~bus_wdata_i[PMPLF_CMD_UNLOCK_BIT]) begin // [RULE_01]
        if (st_q.seq == PMPLF_SEQ_READY && !st_q.engaged) begin // [RULE_02]
          st_d.engaged    = 1'b1;
          st_d.stored_key = st_q.entry_key;
        end
        st_d.seq = PMPLF_SEQ_IDLE;
      end else if (bus_wdata_i[PMPLF_CMD_UNLOCK_BIT] &
                   ~bus_wdata_i[PMPLF_CMD_LOCK_BIT]) begin // [RULE_01]
        if (st_q.seq == PMPLF_SEQ_READY && st_q.engaged &&
            st_q.entry_key == st_q.stored_key) begin // [RULE_03]
          st_d.engaged = 1'b0;
        end
        st_d.seq = PMPLF_SEQ_IDLE;
      end
    end

    // A fault arriving with a clear is kept only if take_fault accepts it against the old record; otherwise it is lost.
    if (clear_write) begin
      st_d.fault_held    = 1'b0; // [RULE_18]
      st_d.fault_address = PMPLF_WORD_RST;
      st_d.fault_status  = PMPLF_WORD_RST;
    end
    if (take_fault) begin
      st_d.fault_held    = 1'b1; // [RULE_07]
      st_d.fault_address = fault_addr_i; // [RULE_09]
      st_d.fault_status  = new_status;
      st_d.exception     = 1'b1; // [RULE_17]
    end

    // Read data for the cycle after the strobe; write-only and unmapped read zero.
    if (bus_rd_i) begin
      if (hit(bus_addr_i, PMPLF_FAULT_ADDRESS_OFS)) begin // [RULE_08]
        st_d.rdata = st_q.fault_address;
      end else if (hit(bus_addr_i, PMPLF_FAULT_STATUS_OFS)) begin // [RULE_08]
        st_d.rdata = st_q.fault_status;
      end else if (hit(bus_addr_i, PMPLF_LOCK_STATE_OFS)) begin
        st_d.rdata[PMPLF_ENGAGED_BIT] = st_q.engaged; // [RULE_04]
      end
    end
  end

  // State register.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q.engaged       <= 1'b0;
      st_q.stored_key    <= PMPLF_KEY_RST;
      st_q.entry_key     <= PMPLF_KEY_RST;
      st_q.seq           <= PMPLF_SEQ_IDLE;
      st_q.fault_held    <= 1'b0;
      st_q.fault_address <= PMPLF_WORD_RST;
      st_q.fault_status  <= PMPLF_WORD_RST;
      st_q.exception     <= 1'b0;
      st_q.rdata         <= PMPLF_WORD_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rdata_o       = st_q.rdata;
  assign fault_exception_o = st_q.exception;
  assign engaged_flag_o    = st_q.engaged;

endmodule
